// ### rtl/rsn_pkg.sv
// Constants, field layout and register map of the remote I/O satellite node
package rsn_pkg;
	// Clock and link rates
	localparam int CLK_KHZ = 200000;
	localparam int RATE12_KBPS = 12000;
	localparam int RATE6_KBPS = 6000;
	localparam int RATE3_KBPS = 3000;
	localparam logic [6:0] BIT12_CYC = 7'(CLK_KHZ / RATE12_KBPS);
	localparam logic [6:0] BIT6_CYC = 7'(CLK_KHZ / RATE6_KBPS);
	localparam logic [6:0] BIT3_CYC = 7'(CLK_KHZ / RATE3_KBPS);
	localparam logic [1:0] RATE_12 = 2'h0;
	localparam logic [1:0] RATE_6 = 2'h1;
	// Scan-ok timeout
	localparam int SCAN_TO_US = 1000;
	localparam int SCAN_TO_CYC = SCAN_TO_US * (CLK_KHZ / 1000);
	// Frame layout, bits after the start bit, LSB first
	localparam int AW = 6;
	localparam int CW = 4;
	localparam int DW = 16;
	localparam int F_ADDR = 0;
	localparam int F_CMD = 6;
	localparam int F_DATA = 10;
	localparam int F_STOP = 26;
	localparam logic [4:0] RX_LAST = 5'h1a;
	localparam logic [4:0] TX_LAST = 5'h17;
	localparam logic [3:0] CMD_IO = 4'h0;
	localparam logic [5:0] ADDR_NONE = 6'h00;
	// Register map
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_OUTS = 8'h08;
	localparam logic [7:0] A_INS = 8'h0c;
	localparam logic [7:0] A_LOG = 8'h10;
	localparam int C_HALF = 2;
	localparam int C_HS = 3;
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	// Frame log
	localparam int LOG_W = 20;
	localparam int LOG_D = 32;
	// Pin modes
	localparam logic [2:0] M_IN = 3'h0;
	localparam logic [2:0] M_OUT4 = 3'h1;
	localparam logic [2:0] M_OUT8 = 3'h2;
	localparam logic [2:0] M_OUT12 = 3'h3;
	localparam logic [2:0] M_OUT16 = 3'h4;
	localparam logic [2:0] M_HI8 = 3'h5;
	localparam logic [2:0] M_PWM_I = 3'h6;
	localparam logic [2:0] M_PWM_M = 3'h7;
	localparam int PWM_W = 8;
	localparam int DIR_BIT = 15;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rsn_rx_e;
endpackage : rsn_pkg

// ### rtl/rsn_node.sv
// Satellite node core, frame log FIFO and AXI4-Lite register slave
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Frame log FIFO
module rsn_fifo #(
	parameter int W = 20,
	parameter int D = 32
) (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AB = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AB-1:0] wp_q;
	logic [AB-1:0] rp_q;
	logic [AB:0] cnt_q;
	logic push;
	logic pop;

	// Honest full and empty
	assign in_ready_o = cnt_q != (AB+1)'(D);
	assign out_valid_o = cnt_q != '0;
	assign out_data_o = mem[rp_q];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	// Storage
	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[wp_q] <= in_data_i;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wp_q <= wp_q + 1'b1;
			if (pop) rp_q <= rp_q + 1'b1;
			cnt_q <= cnt_q + (AB+1)'(push) - (AB+1)'(pop);
		end
	end
endmodule : rsn_fifo

// Satellite node top
module rsn_node #(
	parameter int SCAN_TO_CYC = rsn_pkg::SCAN_TO_CYC
) (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic [5:0] node_address_i,
	input wire logic [2:0] mode_select_pins_i,
	input wire logic force_clear_i,
	input wire logic rxd_i,
	output logic txd_o,
	output logic txd_oe_o,
	output logic transmit_enable_o,
	output logic update_strobe_o,
	output logic capture_strobe_o,
	output logic scan_ok_n_o,
	input wire logic [15:0] user_pins_i,
	output logic [15:0] user_pins_o,
	output logic [15:0] user_pins_oe_o,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	rsn_pkg::rsn_rx_e rx_st_q;
	logic [6:0] rx_cnt_q;
	logic [4:0] rx_n_q;
	logic [26:0] rx_sr_q;
	logic rx_done_q;
	logic tx_en_q;
	logic txd_q;
	logic [22:0] tx_sr_q;
	logic [6:0] tx_cnt_q;
	logic [4:0] tx_n_q;
	logic go_q;
	logic [15:0] rep_q;
	logic [15:0] out_terms_q;
	logic upd_q;
	logic cap_q;
	logic scan_n_q;
	logic [19:0] scan_cnt_q;
	logic seen_q;
	logic link_q;
	logic [3:0] last_cmd_q;
	logic [3:0] ctrl_q;
	logic [2:0] mode_q;
	logic [15:0] pins_q;
	logic [15:0] oe_q;
	logic [7:0] pwm_q;
	logic awready_q, wready_q, bvalid_q, aw_have_q, w_have_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q;
	logic arready_q, rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [31:0] rd_d;
	logic [1:0] rresp_d;
	logic [6:0] bcyc;
	logic [15:0] mask;
	logic [15:0] in_terms;
	logic [15:0] rx_data;
	logic [3:0] rx_cmd;
	logic frame_ok, match, accept, cmd0, load, tx_end, half, hs_en, scan_to;
	logic log_rdy, log_vld, pop, wr_en;
	logic [19:0] log_data;

	// Bit period for the selected rate
	function automatic logic [6:0] bit_cyc(input logic [1:0] r);
		if (r == rsn_pkg::RATE_12) return rsn_pkg::BIT12_CYC;
		else if (r == rsn_pkg::RATE_6) return rsn_pkg::BIT6_CYC;
		else return rsn_pkg::BIT3_CYC;
	endfunction : bit_cyc

	// Pins driven as outputs in each mode
	function automatic logic [15:0] out_mask(input logic [2:0] m);
		case (m)
			rsn_pkg::M_OUT4: return 16'h000f;
			rsn_pkg::M_OUT8: return 16'h00ff;
			rsn_pkg::M_OUT12: return 16'h0fff;
			rsn_pkg::M_OUT16: return 16'hffff;
			rsn_pkg::M_HI8: return 16'hff00;
			rsn_pkg::M_PWM_I: return 16'h0001;
			rsn_pkg::M_PWM_M: return 16'h0003;
			default: return 16'h0000;
		endcase
	endfunction : out_mask

	// Frame decode and acceptance
	assign bcyc = bit_cyc(ctrl_q[1:0]);
	assign half = ctrl_q[rsn_pkg::C_HALF];
	assign hs_en = ctrl_q[rsn_pkg::C_HS];
	assign rx_data = rx_sr_q[rsn_pkg::F_DATA +: rsn_pkg::DW];
	assign rx_cmd = rx_sr_q[rsn_pkg::F_CMD +: rsn_pkg::CW];
	assign frame_ok = rx_done_q && rx_sr_q[rsn_pkg::F_STOP];
	assign match = rx_sr_q[rsn_pkg::F_ADDR +: rsn_pkg::AW] == node_address_i
		&& node_address_i != rsn_pkg::ADDR_NONE;
	assign accept = frame_ok && match && log_rdy && !tx_en_q;
	assign cmd0 = rx_cmd == rsn_pkg::CMD_IO;
	assign load = accept && cmd0 && (!hs_en || link_q);
	assign tx_end = tx_en_q && tx_cnt_q == '0 && tx_n_q == '0;
	assign scan_to = scan_cnt_q == 20'(SCAN_TO_CYC - 1);
	assign mask = out_mask(mode_q);
	assign in_terms = user_pins_i & ~mask;

	// Receiver: start bit checked at mid bit, then mid-bit samples
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			rx_st_q <= rsn_pkg::RX_IDLE;
			rx_cnt_q <= '0;
			rx_n_q <= '0;
			rx_sr_q <= '0;
			rx_done_q <= 1'b0;
		end else begin
			rx_done_q <= 1'b0;
			case (rx_st_q)
				rsn_pkg::RX_IDLE: begin
					if (!rxd_i && !(half && tx_en_q)) begin
						rx_st_q <= rsn_pkg::RX_START;
						rx_cnt_q <= bcyc >> 1;
					end
				end
				rsn_pkg::RX_START: begin
					if (rx_cnt_q == '0) begin
						rx_st_q <= rxd_i ? rsn_pkg::RX_IDLE : rsn_pkg::RX_DATA;
						rx_cnt_q <= bcyc - 7'h01;
						rx_n_q <= '0;
					end else begin
						rx_cnt_q <= rx_cnt_q - 7'h01;
					end
				end
				rsn_pkg::RX_DATA: begin
					if (rx_cnt_q == '0) begin
						rx_sr_q <= {rxd_i, rx_sr_q[26:1]};
						rx_cnt_q <= bcyc - 7'h01;
						rx_n_q <= rx_n_q + 5'h01;
						if (rx_n_q == rsn_pkg::RX_LAST) begin
							rx_done_q <= 1'b1;
							rx_st_q <= rsn_pkg::RX_IDLE;
						end
					end else begin
						rx_cnt_q <= rx_cnt_q - 7'h01;
					end
				end
				default: rx_st_q <= rsn_pkg::RX_IDLE;
			endcase
		end
	end

	// Reply capture: inputs for command 0, zero word otherwise
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			go_q <= 1'b0;
			rep_q <= '0;
			cap_q <= 1'b0;
			last_cmd_q <= '0;
		end else begin
			go_q <= accept;
			cap_q <= accept && cmd0;
			if (accept) begin
				rep_q <= cmd0 ? in_terms : 16'h0000;
				last_cmd_q <= rx_cmd;
			end
		end
	end

	// Transmitter; the enable spans start bit to stop bit
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			tx_en_q <= 1'b0;
			txd_q <= 1'b1;
			tx_sr_q <= '0;
			tx_cnt_q <= '0;
			tx_n_q <= '0;
		end else if (go_q) begin
			tx_en_q <= 1'b1;
			txd_q <= 1'b0;
			tx_sr_q <= {1'b1, rep_q, node_address_i};
			tx_cnt_q <= bcyc - 7'h01;
			tx_n_q <= rsn_pkg::TX_LAST;
		end else if (tx_en_q) begin
			if (tx_cnt_q != '0) begin
				tx_cnt_q <= tx_cnt_q - 7'h01;
			end else if (tx_n_q == '0) begin
				tx_en_q <= 1'b0;
				txd_q <= 1'b1;
			end else begin
				txd_q <= tx_sr_q[0];
				tx_sr_q <= {1'b1, tx_sr_q[22:1]};
				tx_n_q <= tx_n_q - 5'h01;
				tx_cnt_q <= bcyc - 7'h01;
			end
		end
	end

	// Output terminals; force-clear wins over a load
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			out_terms_q <= '0;
			upd_q <= 1'b0;
		end else begin
			upd_q <= load && !force_clear_i;
			if (force_clear_i) out_terms_q <= '0;
			else if (load) out_terms_q <= rx_data;
		end
	end

	// Scan-ok flag and handshake link state, both dropped on timeout
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			scan_n_q <= 1'b1;
			scan_cnt_q <= '0;
			seen_q <= 1'b0;
			link_q <= 1'b0;
		end else begin
			// Counter restarts on every accepted frame and reply end, then parks at the limit
			if (tx_end || accept) scan_cnt_q <= '0;
			else if (!scan_to) scan_cnt_q <= scan_cnt_q + 20'h00001;
			if (tx_end) scan_n_q <= 1'b0;
			else if (scan_to) scan_n_q <= 1'b1;
			// An accepted frame wins over a timeout in the same cycle
			if (accept) begin
				seen_q <= 1'b1;
				link_q <= seen_q;
			end else if (scan_to) begin
				seen_q <= 1'b0;
				link_q <= 1'b0;
			end
		end
	end

	// Pin routing and PWM
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			mode_q <= rsn_pkg::M_IN;
			pins_q <= '0;
			oe_q <= '0;
			pwm_q <= '0;
		end else begin
			mode_q <= mode_select_pins_i;
			pwm_q <= pwm_q + 8'h01;
			oe_q <= mask;
			if (mode_q == rsn_pkg::M_PWM_I || mode_q == rsn_pkg::M_PWM_M) begin
				pins_q <= {14'h0000, out_terms_q[rsn_pkg::DIR_BIT] && mode_q == rsn_pkg::M_PWM_M,
					pwm_q < out_terms_q[rsn_pkg::PWM_W-1:0]};
			end else begin
				pins_q <= out_terms_q & mask;
			end
		end
	end

	// Log of accepted frames; a full log refuses frames
	rsn_fifo #(.W(rsn_pkg::LOG_W), .D(rsn_pkg::LOG_D)) u_log (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.in_valid_i(accept),
		.in_ready_o(log_rdy),
		.in_data_i({rx_cmd, rx_data}),
		.out_valid_o(log_vld),
		.out_ready_i(pop),
		.out_data_o(log_data)
	);
	assign pop = s_axi_arready && s_axi_arvalid && s_axi_araddr == rsn_pkg::A_LOG;

	// AXI write channels taken in either order
	assign wr_en = aw_have_q && w_have_q && !bvalid_q;
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= rsn_pkg::RESP_OK;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else begin
			if (awready_q && s_axi_awvalid) begin
				awaddr_q <= s_axi_awaddr;
				awready_q <= 1'b0;
				aw_have_q <= 1'b1;
			end
			if (wready_q && s_axi_wvalid) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				wready_q <= 1'b0;
				w_have_q <= 1'b1;
			end
			if (wr_en) begin
				bvalid_q <= 1'b1;
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bresp_q <= awaddr_q == rsn_pkg::A_CTRL ? rsn_pkg::RESP_OK : rsn_pkg::RESP_ERR;
			end
			if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// Control register
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) ctrl_q <= rsn_pkg::CTRL_RST;
		else if (wr_en && awaddr_q == rsn_pkg::A_CTRL && wstrb_q[0]) ctrl_q <= wdata_q[3:0];
	end

	// Read decode
	always_comb begin
		rd_d = '0;
		rresp_d = rsn_pkg::RESP_OK;
		if (s_axi_araddr == rsn_pkg::A_CTRL) rd_d = {28'h0000000, ctrl_q};
		else if (s_axi_araddr == rsn_pkg::A_STAT) rd_d = {18'h00000, node_address_i, last_cmd_q,
			!log_rdy, log_vld, link_q, !scan_n_q};
		else if (s_axi_araddr == rsn_pkg::A_OUTS) rd_d = {16'h0000, out_terms_q};
		else if (s_axi_araddr == rsn_pkg::A_INS) rd_d = {16'h0000, in_terms};
		else if (s_axi_araddr == rsn_pkg::A_LOG) rd_d = {log_vld, 11'h000, log_data};
		else rresp_d = rsn_pkg::RESP_ERR;
	end

	// AXI read channel
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= rsn_pkg::RESP_OK;
		end else if (arready_q && s_axi_arvalid) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_d;
			rresp_q <= rresp_d;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// Output ports straight from flops
	assign txd_o = txd_q;
	assign txd_oe_o = tx_en_q;
	assign transmit_enable_o = tx_en_q;
	assign update_strobe_o = upd_q;
	assign capture_strobe_o = cap_q;
	assign scan_ok_n_o = scan_n_q;
	assign user_pins_o = pins_q;
	assign user_pins_oe_o = oe_q;
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// Checks
	property p_reply;
		@(posedge clock_i) disable iff (!reset_n_i) accept |-> ##2 transmit_enable_o;
	endproperty
	a_reply: assert property (p_reply) else $error("no reply after accepted frame");
	property p_load;
		@(posedge clock_i) disable iff (!reset_n_i) load && !force_clear_i |=> out_terms_q == $past(rx_data);
	endproperty
	a_load: assert property (p_load) else $error("output terminals not loaded");
	property p_mode;
		@(posedge clock_i) disable iff (!reset_n_i) (mode_select_pins_i == rsn_pkg::M_IN)[*2] |=> user_pins_oe_o == '0;
	endproperty
	a_mode: assert property (p_mode) else $error("input mode drives pins");
	property p_cmd;
		@(posedge clock_i) disable iff (!reset_n_i) accept && !cmd0 |=> rep_q == 16'h0000 && !update_strobe_o;
	endproperty
	a_cmd: assert property (p_cmd) else $error("other command not zero reply");
	property p_addr;
		@(posedge clock_i) disable iff (!reset_n_i) node_address_i == rsn_pkg::ADDR_NONE |-> !accept;
	endproperty
	a_addr: assert property (p_addr) else $error("address zero accepted");
	property p_half;
		@(posedge clock_i) disable iff (!reset_n_i)
			half && tx_en_q && rx_st_q == rsn_pkg::RX_IDLE |=> rx_st_q == rsn_pkg::RX_IDLE;
	endproperty
	a_half: assert property (p_half) else $error("receive during half duplex reply");
	property p_clear;
		@(posedge clock_i) disable iff (!reset_n_i) force_clear_i |=> out_terms_q == 16'h0000 && !update_strobe_o;
	endproperty
	a_clear: assert property (p_clear) else $error("force clear ignored");
	property p_miss;
		@(posedge clock_i) disable iff (!reset_n_i) frame_ok && !match |=> !go_q ##1 !$rose(transmit_enable_o);
	endproperty
	a_miss: assert property (p_miss) else $error("reply to foreign address");
	property p_scan;
		@(posedge clock_i) disable iff (!reset_n_i) $fell(transmit_enable_o) |-> !scan_ok_n_o;
	endproperty
	a_scan: assert property (p_scan) else $error("scan ok not low after reply");
	property p_strobe;
		@(posedge clock_i) disable iff (!reset_n_i) load && !force_clear_i |=> update_strobe_o ##1 !update_strobe_o;
	endproperty
	a_strobe: assert property (p_strobe) else $error("update strobe wrong");
endmodule : rsn_node

`default_nettype wire

// ### testbench/rsn_ctrl_model.sv
// Central controller model: sends command frames and collects reply frames
`timescale 1ns/1ps
`default_nettype none
module rsn_ctrl_model (
	input wire logic clock_i,
	input wire logic [6:0] bit_cyc_i,
	input wire logic txd_i,
	output logic rxd_o
);
	int reply_count = 0;
	logic [5:0] reply_addr = 6'h00;
	logic [15:0] reply_data = 16'h0000;
	logic reply_stop = 1'b0;
	logic [22:0] sh;
	initial rxd_o = 1'b1;
	// Send one command frame LSB first, then hold the idle level for one bit
	task automatic send(input logic [5:0] a, input logic [3:0] c, input logic [15:0] d);
		logic [27:0] f;
		f = {1'b1, d, c, a, 1'b0};
		@(posedge clock_i);
		for (int i = 0; i < 28; i++) begin
			rxd_o <= f[i];
			repeat (bit_cyc_i) @(posedge clock_i);
		end
		rxd_o <= 1'b1;
		repeat (bit_cyc_i) @(posedge clock_i);
	endtask : send
	// Collect reply frames, sampling each bit at its middle
	initial forever begin
		@(posedge clock_i);
		if (txd_i === 1'b0) begin
			repeat (bit_cyc_i / 2) @(posedge clock_i);
			for (int i = 0; i < 23; i++) begin
				repeat (bit_cyc_i) @(posedge clock_i);
				sh[i] = txd_i;
			end
			reply_addr = sh[5:0];
			reply_data = sh[21:6];
			reply_stop = sh[22];
			reply_count++;
		end
	end
endmodule : rsn_ctrl_model
`default_nettype wire

// ### testbench/test_remote_io_satellite_node.sv
// Testbench of the remote I/O satellite node
`timescale 1ns/1ps
`default_nettype none
module test_remote_io_satellite_node;
	localparam logic [5:0] NODE = 6'h2a;
	localparam logic [15:0] PINS = 16'h3c5a;
	logic clock_i, reset_n_i, force_clear_i, rxd, txd_o, txd_oe_o, transmit_enable_output, upd, cap, scan_ok_n;
	logic [2:0] mode;
	logic [15:0] pins_o, pins_oe;
	logic [7:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, rd_d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	logic [6:0] bitc;
	wire txd_line;
	int bad_count = 0;
	int n_tests = 0;
	int n_upd = 0;
	int n_cap = 0;
	int txe_cyc = 0;
	int oe_cyc = 0;
	logic [15:0] masks [6] = '{16'h0000, 16'h000f, 16'h00ff, 16'h0fff, 16'hffff, 16'hff00};
	// Released reply line is pulled high
	assign txd_line = txd_oe_o ? txd_o : 1'b1;
	rsn_node #(.SCAN_TO_CYC(2000)) DUT (.clock_i(clock_i), .reset_n_i(reset_n_i), .node_address_i(NODE),
		.mode_select_pins_i(mode), .force_clear_i(force_clear_i), .rxd_i(rxd), .txd_o(txd_o),
		.txd_oe_o(txd_oe_o), .transmit_enable_o(transmit_enable_output), .update_strobe_o(upd), .capture_strobe_o(cap),
		.scan_ok_n_o(scan_ok_n), .user_pins_i(PINS), .user_pins_o(pins_o), .user_pins_oe_o(pins_oe),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	rsn_ctrl_model cm (.clock_i(clock_i), .bit_cyc_i(bitc), .txd_i(txd_line), .rxd_o(rxd));
	// Clock
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	// Strobe and enable counters, on the falling edge so frame can clear the enable counters at a rising one
	always @(negedge clock_i) begin
		n_upd <= n_upd + int'(upd === 1'b1);
		n_cap <= n_cap + int'(cap === 1'b1);
		txe_cyc <= txe_cyc + int'(transmit_enable_output === 1'b1);
		oe_cyc <= oe_cyc + int'(txd_oe_o === 1'b1);
	end
	task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic results();
		$display("checks %0d errors %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	// Bus write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(posedge clock_i);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				resp = bresp;
				bready <= 1'b0;
				return;
			end
		end
		check("bvalid", 0, 1);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clock_i);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(posedge clock_i);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				rd_d = rdata;
				resp = rresp;
				rready <= 1'b0;
				return;
			end
		end
		check("rvalid", 0, 1);
	endtask : rd
	// One command frame, waiting a bounded time for the reply
	task automatic frame(input logic [5:0] a, input logic [3:0] c, input logic [15:0] d, input logic rep);
		int c0;
		c0 = cm.reply_count;
		txe_cyc = 0;
		oe_cyc = 0;
		cm.send(a, c, d);
		for (int i = 0; i < 40 * bitc && cm.reply_count == c0; i++) @(posedge clock_i);
		repeat (bitc + 4) @(posedge clock_i);
		check("reply", 32'(cm.reply_count - c0), 32'(rep));
	endtask : frame
	// Watchdog
	initial begin
		repeat (90000) @(posedge clock_i);
		bad_count++;
		results();
	end
	// Main sequence
	initial begin
		reset_n_i = 1'b0; force_clear_i = 1'b0; mode = rsn_pkg::M_HI8; bitc = rsn_pkg::BIT12_CYC;
		awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hf;
		awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
		repeat (6) @(posedge clock_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		check("scan_ok_n", scan_ok_n, 1);
		check("txe", transmit_enable_output, 0);
		rd(rsn_pkg::A_CTRL);
		check("ctrl", rd_d, 0);
		rd(rsn_pkg::A_STAT);
		check("addr", rd_d[13:8], NODE);
		wr(8'h14, 32'h1);
		check("bresp", resp, rsn_pkg::RESP_ERR);
		wr(rsn_pkg::A_STAT, 32'h1);
		check("bresp ro", resp, rsn_pkg::RESP_ERR);
		rd(8'h14);
		check("rresp", resp, rsn_pkg::RESP_ERR);
		// Addressed command 0: load outputs and reply with inputs
		frame(NODE, 4'h0, 16'hbeef, 1'b1);
		check("rep addr", cm.reply_addr, NODE);
		check("rep data", cm.reply_data, PINS & 16'h00ff);
		check("rep stop", cm.reply_stop, 1);
		check("txe cyc", txe_cyc, 24 * bitc);
		check("oe cyc", oe_cyc, 24 * bitc);
		check("upd", n_upd, 1);
		check("cap", n_cap, 1);
		check("pins", pins_o, 16'hbe00);
		check("scan ok", scan_ok_n, 0);
		rd(rsn_pkg::A_OUTS);
		check("outs", rd_d, 32'h0000beef);
		// Other command: zero data, no change
		frame(NODE, 4'h3, 16'h1234, 1'b1);
		check("cmd data", cm.reply_data, 0);
		check("cmd pins", pins_o, 16'hbe00);
		check("cmd upd", n_upd, 1);
		// Foreign address: silence, no change
		frame(NODE ^ 6'h01, 4'h0, 16'h5555, 1'b0);
		check("nm pins", pins_o, 16'hbe00);
		// Force clear wins over a load
		force_clear_i <= 1'b1;
		frame(NODE, 4'h0, 16'hffff, 1'b1);
		check("clr pins", pins_o, 0);
		rd(rsn_pkg::A_OUTS);
		check("clr outs", rd_d, 0);
		force_clear_i <= 1'b0;
		repeat (2100) @(posedge clock_i);
		check("scan to", scan_ok_n, 1);
		// Handshake: the third frame after a timeout is the first to load
		wr(rsn_pkg::A_CTRL, 32'(1 << rsn_pkg::C_HS));
		frame(NODE, 4'h0, 16'h1100, 1'b1);
		check("hs pins 1", pins_o, 0);
		frame(NODE, 4'h0, 16'h1100, 1'b1);
		rd(rsn_pkg::A_STAT);
		check("hs link", rd_d[1], 1);
		check("hs pins 2", pins_o, 0);
		frame(NODE, 4'h0, 16'h1100, 1'b1);
		check("hs pins 3", pins_o, 16'h1100);
		// Pin mode masks of modes M_IN to M_HI8, PWM modes not covered
		for (int m = 0; m < 6; m++) begin
			mode <= 3'(m);
			repeat (3) @(posedge clock_i);
			check("oe", pins_oe, masks[m]);
			rd(rsn_pkg::A_INS);
			check("ins", rd_d, 32'(PINS & ~masks[m]));
		end
		// Slower link rate
		mode <= rsn_pkg::M_OUT8;
		wr(rsn_pkg::A_CTRL, 32'(rsn_pkg::RATE_6) | 32'(1 << rsn_pkg::C_HALF));
		bitc = rsn_pkg::BIT6_CYC;
		frame(NODE, 4'h0, 16'h0f0f, 1'b1);
		check("6m data", cm.reply_data, PINS & 16'hff00);
		check("6m pins", pins_o, 16'h000f);
		wr(rsn_pkg::A_CTRL, 32'(rsn_pkg::RATE_12));
		bitc = rsn_pkg::BIT12_CYC;
		// Frame log: drain, fill until refused, drain again
		for (int i = 0; i < 40; i++) begin
			rd(rsn_pkg::A_LOG);
			if (rd_d[31] !== 1'b1) break;
		end
		for (int i = 0; i < 32; i++) frame(NODE, 4'h0, 16'(i), 1'b1);
		rd(rsn_pkg::A_STAT);
		check("full", rd_d[3], 1);
		frame(NODE, 4'h0, 16'h7777, 1'b0);
		for (int i = 0; i < 32; i++) begin
			rd(rsn_pkg::A_LOG);
			check("log", {rd_d[31], rd_d[19:0]}, {1'b1, 4'h0, 16'(i)});
		end
		rd(rsn_pkg::A_LOG);
		check("empty", rd_d[31], 0);
		results();
	end
endmodule : test_remote_io_satellite_node
`default_nettype wire
